// ===== sio_cfg.svh
// offsets, field positions, reset values and timing for the serial port
`ifndef SIO_CFG_SVH
`define SIO_CFG_SVH

// register offsets on the plain register port
`define SIO_OFS_CTRL    2'h0
`define SIO_OFS_STAT    2'h1
`define SIO_OFS_DATA    2'h2

// control register field positions
`define SIO_CTL_CLK_LSB 0
`define SIO_CTL_CLK_MSB 2
`define SIO_CTL_ORDER   3
`define SIO_CTL_MODE_LSB 4
`define SIO_CTL_MODE_MSB 5
`define SIO_CTL_START   6
`define SIO_CTL_ABORT   7

// status register field positions
`define SIO_ST_ACTIVE   7
`define SIO_ST_SHIFT    6
`define SIO_ST_TXEMPTY  5
`define SIO_ST_RXFULL   4
`define SIO_ST_TXUNDER  3
`define SIO_ST_RXOVER   2

// reset values
`define SIO_CTRL_RST    8'h00
`define SIO_STAT_RST    8'h20

// field codes
`define SIO_MODE_TX     2'h0
`define SIO_MODE_RX     2'h1
`define SIO_CLK_EXT     3'h7

// internal serial clock half period in system clocks
`define SIO_SCK_HALF    4
// bits per byte
`define SIO_BITS        4'h8

`endif

// ===== sio_pkg.sv
// types shared by the synchronous serial port
`default_nettype none

package sio_pkg;

   // one request on the register port
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_s;

   // complete state of the serial port
   typedef struct packed {
      logic [2:0] sck_sync;
      logic       sck_lvl;
      logic [2:0] sdi_sync;
      logic       sdi_lvl;
      logic [7:0] div;
      logic       sck_int;
      logic       sck_oe;
      logic [2:0] clk_sel;
      logic       lsb_first;
      logic [1:0] mode;
      logic       start;
      logic       active;
      logic       shift_cnt;
      logic       tx_empty;
      logic       rx_full;
      logic       tx_under;
      logic       rx_over;
      logic [7:0] tx_buf;
      logic [7:0] rx_buf;
      logic [7:0] shreg;
      logic [3:0] bitcnt;
      logic       load_pend;
      logic       irq_pend;
      logic       sdo;
      logic       irq;
      logic [7:0] rdata;
   } state_s;

endpackage : sio_pkg

`default_nettype wire

// ===== sync_serial_tx_rx_shifter.sv
// clocked synchronous serial port: transmit and receive shifter
//
// Summary of operation
// - transmit bits change on clock falling edge
// - receive bits sampled on clock rising edge
// - one bit order: 0 msb first, 1 lsb
// - mode 00 transmit only, 01 receive only
// - buffer write clears transmit empty flag
// - active flag sets at falling edge after start
// - shift count flag high falls one to eight
// - empty set at rise, interrupt next fall
// - internal transmit waits for buffered data
// - internal clock loads within one period
// - external clock loads at first falling edge
// - internal clock waits high for next byte
// - early written byte follows with no gap
// - external start without data flags underrun
// - clearing start finishes byte, then stops
// - abort stops and resets state at once
// - full byte copied, full flag, interrupt
// - reading receive buffer clears full flag
// - internal receive waits until buffer read
// - unread buffer at byte end flags overrun
// - clock select 111 external, else internal
// - error flags clear only by writing zero or by abort
// - internal clock idles high outside transfers
`include "sio_cfg.svh"
`default_nettype none

module sync_serial_tx_rx_shifter
   import sio_pkg::*;
#(
   parameter int unsigned SCK_HALF = `SIO_SCK_HALF
) (
   // clock and reset
   input  wire logic     ref_clk_in,
   input  wire logic     arst_n_in,
   // register port
   input  wire bus_req_s bus_in,
   output logic [7:0]    rdata_out,
   // serial pins
   input  wire logic     sck_in,
   output logic          sck_out,
   output logic          sck_oe_out,
   input  wire logic     sdi_in,
   output logic          sdo_out,
   // interrupt request
   output logic          serial_irq_out
);

   // the half period counter is eight bits wide
   if (SCK_HALF < 1 || SCK_HALF > 255) begin : g_chk
      $error("SCK_HALF must lie in 1..255");
   end

   localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);

   state_s s;
   state_s next_s;

   // pick the bit to drive from a byte by bit order
   function automatic logic first_bit(input logic [7:0] b,
                                      input logic       lsb);
      first_bit = lsb ? b[0] : b[7];
   endfunction

   // all serial and register behaviour in one next state process
   always_comb begin
      logic       ext;
      logic       is_tx;
      logic       is_rx;
      logic       ready;
      logic       allowed;
      logic       e_fall;
      logic       e_rise;
      logic       i_fall;
      logic       i_rise;
      logic       fall;
      logic       rise;
      logic       rd_rx;
      logic [7:0] sh;
      logic [7:0] smp;
      ext     = 1'b0;
      is_tx   = 1'b0;
      is_rx   = 1'b0;
      ready   = 1'b0;
      allowed = 1'b0;
      e_fall  = 1'b0;
      e_rise  = 1'b0;
      i_fall  = 1'b0;
      i_rise  = 1'b0;
      fall    = 1'b0;
      rise    = 1'b0;
      rd_rx   = 1'b0;
      sh      = 8'h00;
      smp     = 8'h00;

      next_s       = s;
      next_s.irq   = 1'b0;
      next_s.rdata = 8'h00;

      ext   = (s.clk_sel == `SIO_CLK_EXT);
      is_tx = (s.mode == `SIO_MODE_TX);
      is_rx = (s.mode == `SIO_MODE_RX);
      rd_rx = bus_in.rd && (bus_in.addr == `SIO_OFS_DATA);

      // pin synchronisers; a change counts once stages two and three agree
      next_s.sck_sync = {s.sck_sync[1:0], sck_in};
      next_s.sdi_sync = {s.sdi_sync[1:0], sdi_in};
      if (s.sck_sync[1] == s.sck_sync[2]) begin
         next_s.sck_lvl = s.sck_sync[2];
         e_fall = s.sck_lvl && !s.sck_sync[2];
         e_rise = !s.sck_lvl && s.sck_sync[2];
      end
      if (s.sdi_sync[1] == s.sdi_sync[2]) begin
         next_s.sdi_lvl = s.sdi_sync[2];
      end

      // internal clock runs only while a byte is under way or may start
      ready = s.start && ((is_tx && !s.tx_empty) ||
                          (is_rx && !s.rx_full));
      allowed = s.bitcnt != 4'h0 || ready;
      next_s.sck_oe = !ext;
      if (ext) begin
         next_s.sck_int = 1'b1;
         next_s.div     = 8'h00;
      end else if (!allowed && s.sck_int) begin
         next_s.div = 8'h00;
      end else if (s.div == HALF_M1) begin
         // the wait releases within one serial clock period
         next_s.div     = 8'h00;
         next_s.sck_int = !s.sck_int;
         i_fall = s.sck_int;
         i_rise = !s.sck_int;
      end else begin
         next_s.div = s.div + 8'h01;
      end
      fall = ext ? e_fall : i_fall;
      rise = ext ? e_rise : i_rise;

      // register writes come first so that hardware sets win below
      if (bus_in.wr) begin
         case (bus_in.addr)
            `SIO_OFS_CTRL: begin
               next_s.clk_sel =
                  bus_in.wdata[`SIO_CTL_CLK_MSB:`SIO_CTL_CLK_LSB];
               next_s.lsb_first = bus_in.wdata[`SIO_CTL_ORDER];
               next_s.mode =
                  bus_in.wdata[`SIO_CTL_MODE_MSB:`SIO_CTL_MODE_LSB];
               next_s.start = bus_in.wdata[`SIO_CTL_START];
            end
            `SIO_OFS_STAT: begin
               // a one written here leaves the flag alone
               if (!bus_in.wdata[`SIO_ST_TXUNDER]) begin
                  next_s.tx_under = 1'b0;
               end
               if (!bus_in.wdata[`SIO_ST_RXOVER]) begin
                  next_s.rx_over = 1'b0;
                  next_s.rx_full = 1'b0;
               end
            end
            `SIO_OFS_DATA: begin
               // a write while the buffer is occupied is lost
               if (s.tx_empty) begin
                  next_s.tx_buf   = bus_in.wdata;
                  next_s.tx_empty = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // register reads answer in the following cycle
      if (bus_in.rd) begin
         case (bus_in.addr)
            `SIO_OFS_CTRL: begin
               next_s.rdata = {1'b0, s.start, s.mode,
                               s.lsb_first, s.clk_sel};
            end
            `SIO_OFS_STAT: begin
               next_s.rdata = {s.active, s.shift_cnt, s.tx_empty,
                               s.rx_full, s.tx_under, s.rx_over,
                               2'b00};
            end
            `SIO_OFS_DATA: begin
               next_s.rdata   = s.rx_buf;
               next_s.rx_full = 1'b0;
            end
            default: begin
               next_s.rdata = 8'h00;
            end
         endcase
      end

      // stop once the byte has finished and start is clear
      if (s.bitcnt == 4'h0 && !s.start) begin
         next_s.active = 1'b0;
         next_s.sdo    = 1'b1;
      end

      // falling edge: leading edge, drives the output bit
      if (fall) begin
         if (s.irq_pend) begin
            next_s.irq_pend = 1'b0;
            next_s.irq      = 1'b1;
         end
         if (s.bitcnt == 4'h0) begin
            if (s.start && (is_tx || is_rx)) begin
               next_s.active    = 1'b1;
               next_s.shift_cnt = 1'b1;
               next_s.bitcnt    = 4'h1;
               if (is_tx && !s.tx_empty) begin
                  // back to back bytes load here with no idle bit
                  next_s.shreg     = s.tx_buf;
                  next_s.load_pend = 1'b1;
                  next_s.sdo = first_bit(s.tx_buf, s.lsb_first);
               end else if (is_tx) begin
                  // only an external master can get here empty
                  next_s.tx_under = 1'b1;
                  next_s.irq_pend = 1'b1;
                  next_s.sdo      = 1'b1;
               end
            end
         end else if (s.bitcnt < `SIO_BITS) begin
            next_s.bitcnt = s.bitcnt + 4'h1;
            if (s.bitcnt == `SIO_BITS - 4'h1) begin
               next_s.shift_cnt = 1'b0;
            end
            if (is_tx) begin
               sh = s.lsb_first ? {1'b0, s.shreg[7:1]}
                                : {s.shreg[6:0], 1'b0};
               next_s.shreg = sh;
               next_s.sdo   = s.tx_under ? 1'b1
                              : first_bit(sh, s.lsb_first);
            end
         end
      end

      // rising edge: trailing edge, samples the input bit
      if (rise && s.bitcnt != 4'h0) begin
         if (s.load_pend) begin
            next_s.load_pend = 1'b0;
            next_s.tx_empty  = 1'b1;
            next_s.irq_pend  = 1'b1;
         end
         // take the level the filter settles on this cycle: the
         // internal clock rises four cycles after it fell, which
         // is exactly the filter's delay, so the stored level lags
         if (is_rx) begin
            smp = s.lsb_first ? {next_s.sdi_lvl, s.shreg[7:1]}
                              : {s.shreg[6:0], next_s.sdi_lvl};
            next_s.shreg = smp;
         end
         if (s.bitcnt == `SIO_BITS) begin
            next_s.bitcnt = 4'h0;
            if (is_rx) begin
               if (s.rx_over) begin
                  // data is dropped and no request until cleared
                  next_s.rx_over = 1'b1;
               end else if (s.rx_full && !rd_rx) begin
                  next_s.rx_over = 1'b1;
                  next_s.irq     = 1'b1;
               end else begin
                  next_s.rx_buf  = smp;
                  next_s.rx_full = 1'b1;
                  next_s.irq     = 1'b1;
               end
            end
         end
      end

      // abort overrides everything and returns to the idle state
      if (bus_in.wr && bus_in.addr == `SIO_OFS_CTRL &&
          bus_in.wdata[`SIO_CTL_ABORT]) begin
         next_s.start     = 1'b0;
         next_s.active    = 1'b0;
         next_s.shift_cnt = 1'b0;
         next_s.tx_empty  = 1'b1;
         next_s.rx_full   = 1'b0;
         next_s.tx_under  = 1'b0;
         next_s.rx_over   = 1'b0;
         next_s.tx_buf    = 8'h00;
         next_s.rx_buf    = 8'h00;
         next_s.shreg     = 8'h00;
         next_s.bitcnt    = 4'h0;
         next_s.load_pend = 1'b0;
         next_s.irq_pend  = 1'b0;
         next_s.irq       = 1'b0;
         next_s.sdo       = 1'b1;
         next_s.sck_int   = 1'b1;
         next_s.div       = 8'h00;
      end
   end

   // state register; reset takes constants only
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s           <= '0;
         s.sck_sync  <= 3'h7;
         s.sck_lvl   <= 1'b1;
         s.sck_int   <= 1'b1;
         s.sck_oe    <= 1'b1;
         s.tx_empty  <= 1'b1;
         s.sdo       <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign rdata_out      = s.rdata;
   assign sck_out        = s.sck_int;
   assign sck_oe_out     = s.sck_oe;
   assign sdo_out        = s.sdo;
   assign serial_irq_out = s.irq;

endmodule // sync_serial_tx_rx_shifter

`default_nettype wire

// ===== sio_checker.sv
// concurrent checks on the serial port's register port and pins
`default_nettype none

module sio_checker
   import sio_pkg::*;
#(
   parameter int unsigned SCK_HALF = 4
) (
   // clock and reset
   input wire logic       ref_clk_in,
   input wire logic       arst_n_in,
   // register port
   input wire bus_req_s   bus_in,
   input wire logic [7:0] rdata_out,
   // pins and interrupt
   input wire logic       sck_out,
   input wire logic       sck_oe_out,
   input wire logic       sdo_out,
   input wire logic       serial_irq_out
);
   logic       st_rd;
   logic [7:0] low_n;

   // most register checks end in a status read
   assign st_rd = bus_in.rd && bus_in.addr == 2'h1;

   // cycles the internal clock has spent low
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         low_n <= 8'h00;
      else
         low_n <= sck_out ? 8'h00 : low_n + 8'h01;
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);

   a_irq_one_pulse: assert property (
      serial_irq_out |=> !serial_irq_out) else $error("irq too long");
   a_sck_low_width: assert property (
      $rose(sck_out) && sck_oe_out |-> low_n == SCK_HALF)
      else $error("internal clock low time wrong");
   a_sdo_on_fall: assert property (
      $fell(sdo_out) && sck_oe_out |-> !sck_out)
      else $error("data out moved while clock high");
   a_tx_write_clears: assert property (
      bus_in.wr && bus_in.addr == 2'h2 ##2 st_rd |=> !rdata_out[5])
      else $error("buffer write left empty flag set");
   a_rx_read_clears: assert property (
      bus_in.rd && bus_in.addr == 2'h2 ##2 st_rd |=> !rdata_out[4])
      else $error("data read left full flag set");
   a_err_zero_clears: assert property (
      bus_in.wr && bus_in.addr == 2'h1 && !bus_in.wdata[3] ##2 st_rd
      |=> !rdata_out[3]) else $error("underrun flag not cleared");
   a_abort_resets: assert property (
      bus_in.wr && bus_in.addr == 2'h0 && bus_in.wdata[7] ##2 st_rd
      |=> rdata_out == 8'h20) else $error("abort left status dirty");
   a_clk_source: assert property (
      bus_in.wr && bus_in.addr == 2'h0 |-> ##2
      sck_oe_out == ($past(bus_in.wdata[2:0], 2) != 3'h7))
      else $error("clock pin drive wrong for source");
endmodule // sio_checker

bind sync_serial_tx_rx_shifter
   sio_checker #(.SCK_HALF(SCK_HALF)) i_sio_checker (
   .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .bus_in(bus_in),
   .rdata_out(rdata_out), .sck_out(sck_out), .sck_oe_out(sck_oe_out),
   .sdo_out(sdo_out), .serial_irq_out(serial_irq_out));

`default_nettype wire

// ===== sio_partner.sv
// external serial device: optional clock master, shifts bytes both ways
`default_nettype none

module sio_partner (
   // pin levels
   input  wire logic       sck_line_in,
   input  wire logic       sdo_in,
   output var logic        sck_drv_out,
   output var logic        sdi_out,
   // bits seen on data out, newest at bit 0
   output var logic [15:0] got_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tx;
   int         idx;

   initial begin
      sck_drv_out = 1'b1;
      sdi_out = 1'b0;
      got_out = 16'h0000;
      tx = 8'h00;
      idx = 8;
   end

   // new bit on each fall; past the byte the line shows the inverse
   always @(negedge sck_line_in) begin
      sdi_out <= (idx < 8) ? tx[7 - idx] : ~sdi_out;
      idx <= idx + 1;
   end

   // capture data out where the device's partner would
   always @(posedge sck_line_in) begin
      got_out <= {got_out[14:0], sdo_in};
   end

   task automatic load(input logic [7:0] d);
      tx = d;
      idx = 0;
   endtask

   // 160 ns pulses, 80 ns each level, clock rests high between frames
   task automatic pulses(input int n);
      repeat (n) begin
         sck_drv_out = 1'b0;
         #80;
         sck_drv_out = 1'b1;
         #80;
      end
   endtask
endmodule // sio_partner

`default_nettype wire

// ===== testbench.sv
// self-checking bench for the synchronous serial port
`default_nettype none

`define CHK(nm, ex, gt) \
   begin \
      total_checks++; \
      if ((gt) !== (ex)) begin \
         n_fail++; \
         $display("[ERR] %s exp %h got %h", nm, ex, gt); \
      end \
   end

module testbench
   import sio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_in;
   logic        arst_n_in;
   bus_req_s    bus;
   logic [7:0]  rdata;
   logic        sck_o;
   logic        sck_oe;
   logic        sdo;
   logic        irq;
   logic        p_sck;
   logic        sdi;
   logic [15:0] got;
   logic [7:0]  v;
   wire         sck_line;
   int          n_fail;
   int          total_checks;
   int          n_irq;

   // pin level: device drives when internal, else the partner
   assign sck_line = sck_oe ? sck_o : p_sck;

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // interrupt pulses seen
   always @(posedge ref_clk_in) begin
      if (irq === 1'b1) n_irq++;
   end

   sync_serial_tx_rx_shifter i_sync_serial_tx_rx_shifter (
      .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .bus_in(bus),
      .rdata_out(rdata), .sck_in(sck_line), .sck_out(sck_o),
      .sck_oe_out(sck_oe), .sdi_in(sdi), .sdo_out(sdo),
      .serial_irq_out(irq));

   sio_partner i_sio_partner (
      .sck_line_in(sck_line), .sdo_in(sdo), .sck_drv_out(p_sck),
      .sdi_out(sdi), .got_out(got));

   task automatic finish_test;
      if (n_fail == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk_in);
      bus <= '0;
      @(posedge ref_clk_in);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] q);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk_in);
      bus <= '0;
      @(negedge ref_clk_in);
      q = rdata;
      @(posedge ref_clk_in);
   endtask

   task automatic wait_st(input logic [7:0] m, input logic [7:0] x);
      logic [7:0] s;
      repeat (400) begin
         rd(2'h1, s);
         if ((s & m) === x) return;
      end
      n_fail++;
      $display("[ERR] status wait exp %h got %h", x, s & m);
      finish_test();
   endtask

   task automatic ext_frame;
      repeat (4) @(posedge ref_clk_in);
      // pin edges land off the sampling edge of the system clock
      #5;
      i_sio_partner.pulses(8);
      @(posedge ref_clk_in);
   endtask

   initial begin
      arst_n_in = 1'b0;
      bus = '0;
      n_fail = 0;
      total_checks = 0;
      n_irq = 0;
      repeat (8) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      @(posedge ref_clk_in);
      rd(2'h1, v);
      `CHK("status", 8'h20, v)
      rd(2'h3, v);
      `CHK("unmapped", 8'h00, v)
      // internal transmit, msb first, second byte queued early
      wr(2'h0, 8'h40);
      repeat (40) @(posedge ref_clk_in);
      rd(2'h1, v);
      `CHK("no data no start", 8'h00, v & 8'h80)
      wr(2'h2, 8'hA5);
      wait_st(8'h20, 8'h20);
      wr(2'h2, 8'h3C);
      wait_st(8'h20, 8'h20);
      wr(2'h0, 8'h00);
      wait_st(8'h80, 8'h00);
      `CHK("tx pair", 16'hA53C, got)
      `CHK("sdo rest", 1'b1, sdo)
      // internal receive, lsb first: partner sends C1 bit-reversed
      i_sio_partner.load(8'h83);
      wr(2'h0, 8'h58);
      wait_st(8'h10, 8'h10);
      repeat (40) @(posedge ref_clk_in);
      `CHK("clock waits", 1'b1, sck_line)
      wr(2'h0, 8'h18);
      rd(2'h2, v);
      `CHK("rx lsb", 8'hC1, v)
      rd(2'h1, v);
      `CHK("rx drained", 8'h00, v & 8'h90)
      // external transmit with nothing buffered
      wr(2'h0, 8'h47);
      ext_frame();
      rd(2'h1, v);
      `CHK("underrun", 8'h08, v & 8'h08)
      `CHK("sdo held", 8'hFF, got[7:0])
      wr(2'h1, 8'hFF);
      rd(2'h1, v);
      `CHK("error kept", 8'h08, v & 8'h08)
      wr(2'h1, 8'h00);
      rd(2'h1, v);
      `CHK("error cleared", 8'h00, v & 8'h08)
      wr(2'h0, 8'h80);
      rd(2'h1, v);
      `CHK("abort status", 8'h20, v)
      rd(2'h0, v);
      `CHK("abort start", 8'h00, v & 8'h40)
      // external receive, second byte left unread
      i_sio_partner.load(8'h5A);
      wr(2'h0, 8'h57);
      ext_frame();
      rd(2'h1, v);
      `CHK("rx full", 8'h10, v & 8'h14)
      i_sio_partner.load(8'h96);
      ext_frame();
      rd(2'h1, v);
      `CHK("overrun", 8'h14, v & 8'h14)
      rd(2'h2, v);
      `CHK("rx kept", 8'h5A, v)
      // clear the overrun, then read the next byte before another comes
      wr(2'h1, 8'h00);
      i_sio_partner.load(8'hC3);
      ext_frame();
      rd(2'h2, v);
      `CHK("rx in time", 8'hC3, v)
      wr(2'h0, 8'h80);
      // external transmit, lsb first, byte buffered before the master starts
      wr(2'h2, 8'h1E);
      n_irq = 0;
      wr(2'h0, 8'h4F);
      ext_frame();
      `CHK("tx lsb", 8'h78, got[7:0])
      rd(2'h1, v);
      `CHK("tx empty", 8'h20, v & 8'h28)
      `CHK("tx irq", 1, n_irq)
      finish_test();
   end
endmodule // testbench

`default_nettype wire
